// >>> logic/i2cms_map.svh
// Constants of the two-wire master start and receive block
`ifndef I2CMS_MAP_SVH
`define I2CMS_MAP_SVH
`define I2CMS_BIT_START    0
`define I2CMS_BIT_RECEIVE  3
`define I2CMS_BIT_ACK      4
`define I2CMS_CTL2_W       5
`define I2CMS_BRG_W        7
`define I2CMS_BITS         4'h8
`define I2CMS_DATA_W       8
`define I2CMS_FIFO_DEPTH   8
`define I2CMS_CLR_BCL      0
`define I2CMS_CLR_WRITE_COLLISION_FLAG     1
`define I2CMS_CLR_PIF      2
`define I2CMS_CLR_OV       3
`define I2CMS_RESET_BYTE   8'h00
`endif

// >>> logic/i2cms_pkg.sv
// Types of the two-wire master start and receive block
package i2cms_pkg;
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_SETUP = 3'b001,
      ST_HOLD  = 3'b010,
      ST_RX    = 3'b011,
      ST_DONE  = 3'b100
   } i2cms_state_e;
   typedef struct packed {
      logic receive_overflow_flag;
      logic port_interrupt_flag;
      logic buffer_full_flag;
      logic write_collision_flag;
      logic bus_collision_flag;
      logic start_seen;
   } i2cms_status_s;
   typedef struct packed {
      logic ack_sequence_request;
      logic receive_request_bit;
      logic start_request_bit;
   } i2cms_ctl_s;
endpackage : i2cms_pkg

// >>> logic/i2cms_top.sv
// Two-wire bus master: start generation, byte reception and receive FIFO
`timescale 1ns/10ps
`default_nettype none
`include "i2cms_map.svh"

// Receive FIFO, flip-flop storage
module i2cms_fifo #(
   parameter int W = 8,
   parameter int D = 8
) (
   input  wire logic         clk,       // Clock
   input  wire logic         rst_n,     // Sync reset, active low
   input  wire logic [W-1:0] in_data,   // Write data
   input  wire logic         in_valid,  // Write request
   output logic              in_ready,  // Room available
   output logic [W-1:0]      out_data,  // Head word
   output logic              out_valid, // Head word valid
   input  wire logic         out_ready  // Drain accepts
);
   localparam int AW = (D > 1) ? $clog2(D) : 1;
   logic [W-1:0]  mem_reg [D];
   logic [AW-1:0] wr_reg;
   logic [AW-1:0] rd_reg;
   logic [AW:0]   cnt_reg;
   logic          push;
   logic          pop;

   function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
      bump = (p == AW'(D - 1)) ? '0 : p + 1'b1;
   endfunction : bump

   // Handshakes and flags from the count
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   assign in_ready  = (cnt_reg != (AW+1)'(D));
   assign out_valid = (cnt_reg != '0);
   assign out_data  = mem_reg[rd_reg];

   // Storage write
   always_ff @(posedge clk) begin
      if (push) begin
         mem_reg[wr_reg] <= in_data;
      end
   end

   // Pointers and fill count
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wr_reg  <= '0;
         rd_reg  <= '0;
         cnt_reg <= '0;
      end else begin
         if (push) begin
            wr_reg <= bump(wr_reg);
         end
         if (pop) begin
            rd_reg <= bump(rd_reg);
         end
         cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule : i2cms_fifo

// Master core
module i2cms_top #(
   parameter int FIFO_DEPTH = `I2CMS_FIFO_DEPTH
) (
   input  wire logic                      clk,          // 10 MHz clock
   input  wire logic                      rst_n,        // Sync reset, active low
   input  wire logic                      scl_i,        // SCL pin level
   output logic                           scl_o,        // SCL drive value
   output logic                           scl_oe_n,     // SCL drive, low = driven
   input  wire logic                      sda_i,        // SDA pin level
   output logic                           sda_o,        // SDA drive value
   output logic                           sda_oe_n,     // SDA drive, low = driven
   input  wire logic [`I2CMS_BRG_W-1:0]   baud_reload_value, // Baud reload
   input  wire logic                      ctl2_wr,      // Control two write pulse
   input  wire logic [`I2CMS_CTL2_W-1:0]  ctl2_wdata,   // Control two write data
   output i2cms_pkg::i2cms_ctl_s          ctl2,         // Control two bits
   input  wire logic                      buf_wr,       // Data buffer write pulse
   input  wire logic [`I2CMS_DATA_W-1:0]  buf_wdata,    // Data buffer write data
   input  wire logic                      buf_rd,       // Data buffer read pulse
   output logic [`I2CMS_DATA_W-1:0]       port_data_buffer, // Data buffer
   input  wire logic [3:0]                flag_clr,     // Flag clear pulses
   output i2cms_pkg::i2cms_status_s       port_status_reg,  // Status flags
   output logic                           port_idle,    // Port idle
   output logic [`I2CMS_DATA_W-1:0]       rx_data,      // Stream byte
   output logic                           rx_valid,     // Stream byte valid
   input  wire logic                      rx_ready      // Stream accept
);
   i2cms_pkg::i2cms_state_e   state_reg;
   logic [2:0]                scl_sync_reg;
   logic [2:0]                sda_sync_reg;
   logic                      scl_f_reg;
   logic                      sda_f_reg;
   logic                      scl_f_d_reg;
   logic [`I2CMS_BRG_W-1:0]   brg_reg;
   logic                      brg_run_reg;
   logic [3:0]                fall_reg;
   logic [`I2CMS_DATA_W-1:0]  port_shift_register;
   logic                      expire;
   logic                      scl_rise;
   logic                      in_start;
   logic                      bus_free;
   logic                      bus_low;
   logic                      rx_begin;
   logic                      ev_bcl;
   logic                      ev_write_collision_flag;
   logic                      ev_byte;
   logic                      fifo_ready;

   // Pin inputs: three stages, a change counts when stages two and three agree
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         scl_sync_reg <= 3'h7;
         sda_sync_reg <= 3'h7;
         scl_f_reg    <= 1'b1;
         sda_f_reg    <= 1'b1;
         scl_f_d_reg  <= 1'b1;
      end else begin
         scl_sync_reg <= {scl_sync_reg[1:0], scl_i};
         sda_sync_reg <= {sda_sync_reg[1:0], sda_i};
         if (scl_sync_reg[1] == scl_sync_reg[2]) begin
            scl_f_reg <= scl_sync_reg[2];
         end
         if (sda_sync_reg[1] == sda_sync_reg[2]) begin
            sda_f_reg <= sda_sync_reg[2];
         end
         scl_f_d_reg <= scl_f_reg;
      end
   end

   // Decoded conditions
   assign expire   = brg_run_reg && (brg_reg == '0);
   assign scl_rise = scl_f_reg && !scl_f_d_reg;
   assign in_start = (state_reg == i2cms_pkg::ST_SETUP) || (state_reg == i2cms_pkg::ST_HOLD)
                     || ctl2.start_request_bit; // Pending start counts as running
   assign bus_free = scl_f_reg && sda_f_reg;
   assign bus_low  = !scl_f_reg && !sda_f_reg;
   assign rx_begin = (state_reg == i2cms_pkg::ST_IDLE) && !ctl2.start_request_bit
                     && ctl2_wr && ctl2_wdata[`I2CMS_BIT_RECEIVE];
   assign ev_byte  = (state_reg == i2cms_pkg::ST_DONE) && fifo_ready;
   assign ev_write_collision_flag  = buf_wr && (in_start || state_reg == i2cms_pkg::ST_RX);
   assign ev_bcl   = (state_reg == i2cms_pkg::ST_IDLE && ctl2.start_request_bit && bus_low)
                     || (state_reg == i2cms_pkg::ST_SETUP && (!scl_f_reg
                     || (expire && !sda_f_reg)));

   // Sequencer
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_reg <= i2cms_pkg::ST_IDLE;
      end else begin
         case (state_reg)
            i2cms_pkg::ST_IDLE: begin
               if (ctl2.start_request_bit && bus_free) begin
                  state_reg <= i2cms_pkg::ST_SETUP;
               end else if (rx_begin) begin
                  state_reg <= i2cms_pkg::ST_RX;
               end
            end
            i2cms_pkg::ST_SETUP: begin
               if (ev_bcl) begin
                  state_reg <= i2cms_pkg::ST_IDLE;
               end else if (expire) begin
                  state_reg <= i2cms_pkg::ST_HOLD;
               end
            end
            i2cms_pkg::ST_HOLD: begin
               if (expire) begin
                  state_reg <= i2cms_pkg::ST_IDLE;
               end
            end
            i2cms_pkg::ST_RX: begin
               if (expire && scl_o && fall_reg == `I2CMS_BITS - 4'h1) begin
                  state_reg <= i2cms_pkg::ST_DONE;
               end
            end
            i2cms_pkg::ST_DONE: begin
               if (fifo_ready) begin
                  state_reg <= i2cms_pkg::ST_IDLE;
               end
            end
            default: begin
               state_reg <= i2cms_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // Baud rate generator: reload, count down, halt
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         brg_reg     <= '0;
         brg_run_reg <= 1'b0;
      end else if ((state_reg == i2cms_pkg::ST_IDLE && ctl2.start_request_bit && bus_free)
                   || rx_begin) begin
         brg_reg     <= baud_reload_value;
         brg_run_reg <= 1'b1;
      end else if (ev_bcl || (expire && state_reg == i2cms_pkg::ST_HOLD)
                   || state_reg == i2cms_pkg::ST_DONE || state_reg == i2cms_pkg::ST_IDLE) begin
         brg_run_reg <= 1'b0;
      end else if (expire) begin
         brg_reg <= baud_reload_value;
         if (state_reg == i2cms_pkg::ST_RX && fall_reg == `I2CMS_BITS - 4'h1 && scl_o) begin
            brg_run_reg <= 1'b0;
         end
      end else if (brg_run_reg) begin
         brg_reg <= brg_reg - 1'b1;
      end
   end

   // Bus drive: SCL toggles on rollover in receive, SDA low for start
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         scl_o    <= 1'b1;
         scl_oe_n <= 1'b1;
         sda_o    <= 1'b1;
         sda_oe_n <= 1'b1;
      end else begin
         if (state_reg == i2cms_pkg::ST_SETUP && expire && !ev_bcl) begin
            sda_o    <= 1'b0;
            sda_oe_n <= 1'b0;
         end else if (rx_begin) begin
            sda_o    <= 1'b1; // Slave owns SDA while receiving
            sda_oe_n <= 1'b1;
         end
         if (rx_begin) begin
            scl_o    <= 1'b0;
            scl_oe_n <= 1'b0;
         end else if (state_reg == i2cms_pkg::ST_RX && expire) begin
            scl_o    <= !scl_o;
            scl_oe_n <= !scl_o; // Release for high, drive for low
         end
      end
   end

   // Falling edge count and MSB-first shift on generated rising SCL
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         fall_reg            <= 4'h0;
         port_shift_register <= `I2CMS_RESET_BYTE;
      end else begin
         if (rx_begin) begin
            fall_reg <= 4'h0;
         end else if (state_reg == i2cms_pkg::ST_RX && expire && scl_o) begin
            fall_reg <= fall_reg + 4'h1;
         end
         if (state_reg == i2cms_pkg::ST_RX && scl_o && scl_rise) begin
            port_shift_register <= {port_shift_register[`I2CMS_DATA_W-2:0], sda_f_reg};
         end
      end
   end

   // Control two bits
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ctl2 <= '0;
      end else begin
         if (ctl2_wr && !in_start && state_reg != i2cms_pkg::ST_RX
             && state_reg != i2cms_pkg::ST_DONE) begin
            ctl2.start_request_bit    <= ctl2_wdata[`I2CMS_BIT_START] && !rx_begin;
            ctl2.receive_request_bit  <= rx_begin;
            ctl2.ack_sequence_request <= ctl2_wdata[`I2CMS_BIT_ACK];
         end
         if (ev_bcl || (state_reg == i2cms_pkg::ST_HOLD && expire)) begin
            ctl2.start_request_bit <= 1'b0;
         end
         if (ev_byte) begin
            ctl2.receive_request_bit <= 1'b0;
         end
      end
   end

   // Data buffer: refused writes during start and while shifting in ST_RX
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         port_data_buffer <= `I2CMS_RESET_BYTE;
      end else if (ev_byte) begin
         port_data_buffer <= port_shift_register;
      end else if (buf_wr && !ev_write_collision_flag) begin
         port_data_buffer <= buf_wdata;
      end
   end

   // Status flags; a set wins over a clear in the same cycle, except that a collision clears start_seen over its set
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         port_status_reg <= '0;
      end else begin
         if (ev_bcl) begin
            port_status_reg.bus_collision_flag <= 1'b1;
            port_status_reg.start_seen         <= 1'b0;
         end else begin
            if (flag_clr[`I2CMS_CLR_BCL]) begin
               port_status_reg.bus_collision_flag <= 1'b0;
            end
            if (state_reg == i2cms_pkg::ST_SETUP && expire) begin
               port_status_reg.start_seen <= 1'b1;
            end
         end
         if (ev_write_collision_flag) begin
            port_status_reg.write_collision_flag <= 1'b1;
         end else if (flag_clr[`I2CMS_CLR_WRITE_COLLISION_FLAG]) begin
            port_status_reg.write_collision_flag <= 1'b0;
         end
         if (ev_byte) begin
            port_status_reg.port_interrupt_flag <= 1'b1;
            port_status_reg.buffer_full_flag    <= 1'b1;
         end else begin
            if (flag_clr[`I2CMS_CLR_PIF]) begin
               port_status_reg.port_interrupt_flag <= 1'b0;
            end
            if (buf_rd) begin
               port_status_reg.buffer_full_flag <= 1'b0;
            end
         end
         if (ev_byte && port_status_reg.buffer_full_flag) begin
            port_status_reg.receive_overflow_flag <= 1'b1;
         end else if (flag_clr[`I2CMS_CLR_OV]) begin
            port_status_reg.receive_overflow_flag <= 1'b0;
         end
      end
   end

   // Idle indicator
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         port_idle <= 1'b1;
      end else begin
         port_idle <= (state_reg == i2cms_pkg::ST_IDLE) && !rx_begin
                      && !(ctl2.start_request_bit && bus_free);
      end
   end

   // Received bytes also stream out; a full FIFO stalls the hand-off
   i2cms_fifo #(
      .W (`I2CMS_DATA_W),
      .D (FIFO_DEPTH)
   ) u_fifo (
      .clk       (clk),
      .rst_n     (rst_n),
      .in_data   (port_shift_register),
      .in_valid  (state_reg == i2cms_pkg::ST_DONE),
      .in_ready  (fifo_ready),
      .out_data  (rx_data),
      .out_valid (rx_valid),
      .out_ready (rx_ready)
   );
endmodule : i2cms_top
`default_nettype wire

// >>> bench/i2cms_slave_model.sv
// Behavioural two-wire slave that answers master reads and can jam the lines
`timescale 1ns/10ps
`default_nettype none
module i2cms_slave_model (
   input  wire logic       clk,       // Clock
   input  wire logic       rst_n,     // Sync reset, active low
   input  wire logic       scl,       // Resolved SCL level
   input  wire logic       load,      // Arm a byte to send
   input  wire logic [7:0] tx_byte,   // Byte to send
   input  wire logic       hold_scl,  // Jam SCL low on command
   input  wire logic       hold_sda,  // Jam SDA low on command
   output logic            scl_pull_n, // Low = slave pulls SCL
   output logic            sda_pull_n  // Low = slave pulls SDA
);
   logic [7:0] shift_reg;
   logic [3:0] left_reg;
   logic       scl_reg;
   logic       rose_reg;

   // Next bit after each falling SCL that follows a rise, most significant first
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         shift_reg <= 8'hFF;
         left_reg  <= 4'h0;
         scl_reg   <= 1'b1;
         rose_reg  <= 1'b0;
      end else begin
         scl_reg <= scl;
         if (load) begin
            shift_reg <= tx_byte;
            left_reg  <= 4'h8;
            rose_reg  <= 1'b0; // Ignore the fall that opens the transfer
         end else begin
            if (!scl_reg && scl) begin
               rose_reg <= 1'b1;
            end
            if (scl_reg && !scl && left_reg != 4'h0 && rose_reg) begin
               shift_reg <= {shift_reg[6:0], 1'b1};
               left_reg  <= left_reg - 4'h1;
            end
         end
      end
   end

   // Released lines fall back to the pull-up
   assign scl_pull_n = !hold_scl;
   assign sda_pull_n = !((left_reg != 4'h0 && !shift_reg[7]) || hold_sda);
endmodule : i2cms_slave_model
`default_nettype wire

// >>> bench/i2cms_checker_properties.sv
// Concurrent checks on the two-wire master ports
`timescale 1ns/10ps
`default_nettype none
`include "i2cms_map.svh"
module i2cms_checker #(
   parameter int FIFO_DEPTH = 8
) (
   input wire logic                       clk,              // Clock
   input wire logic                       rst_n,            // Sync reset
   input wire logic                       scl_oe_n,         // SCL drive
   input wire logic                       sda_oe_n,         // SDA drive
   input wire logic                       ctl2_wr,          // Control write
   input wire logic [`I2CMS_CTL2_W-1:0]   ctl2_wdata,       // Control data
   input wire i2cms_pkg::i2cms_ctl_s      ctl2,             // Control bits
   input wire logic                       buf_wr,           // Buffer write
   input wire logic                       buf_rd,           // Buffer read
   input wire logic [`I2CMS_DATA_W-1:0]   port_data_buffer, // Buffer
   input wire i2cms_pkg::i2cms_status_s   port_status_reg,  // Flags
   input wire logic                       port_idle         // Idle
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   a_start_sda_low: assert property ($rose(port_status_reg.start_seen) |-> !sda_oe_n && scl_oe_n)
      else $error("start seen without SDA low and SCL high");
   a_start_ends: assert property ($rose(port_status_reg.start_seen) |-> ##[1:129] !ctl2.start_request_bit)
      else $error("start bit not cleared after second period");
   a_start_done_low: assert property ($fell(ctl2.start_request_bit) && !port_status_reg.bus_collision_flag |-> !sda_oe_n)
      else $error("SDA released when start completed");
   a_coll_abort: assert property ($rose(port_status_reg.bus_collision_flag) |-> !ctl2.start_request_bit && sda_oe_n && scl_oe_n ##1 port_idle)
      else $error("collision did not abort the start");
   a_write_collision_flag_start: assert property (buf_wr && ctl2.start_request_bit |=> port_status_reg.write_collision_flag && $stable(port_data_buffer))
      else $error("buffer write during start not refused");
   a_ctl2_locked: assert property (ctl2_wr && ctl2.start_request_bit |=> !$rose(ctl2.receive_request_bit) && !$rose(ctl2.ack_sequence_request))
      else $error("control write taken during start");
   a_rx_refused: assert property (ctl2_wr && ctl2_wdata[`I2CMS_BIT_RECEIVE] && !port_idle |=> !$rose(ctl2.receive_request_bit))
      else $error("receive request taken while busy");
   a_rx_sda_free: assert property (ctl2.receive_request_bit |-> sda_oe_n)
      else $error("SDA driven during receive");
   a_rx_handoff: assert property ($fell(ctl2.receive_request_bit) |-> !scl_oe_n && port_status_reg.buffer_full_flag && port_status_reg.port_interrupt_flag)
      else $error("byte hand-off incomplete");
   a_write_collision_flag_rx: assert property (buf_wr && ctl2.receive_request_bit |=> port_status_reg.write_collision_flag)
      else $error("buffer write during receive not flagged");
   a_bf_cleared: assert property (buf_rd && !ctl2.receive_request_bit |=> !port_status_reg.buffer_full_flag)
      else $error("buffer read left full flag set");
   a_overflow_set: assert property ($fell(ctl2.receive_request_bit) && $past(port_status_reg.buffer_full_flag) && !$past(buf_rd) |-> port_status_reg.receive_overflow_flag)
      else $error("overflow not flagged");
endmodule : i2cms_checker
bind i2cms_top i2cms_checker #(.FIFO_DEPTH(FIFO_DEPTH)) u_checker (
   .clk(clk), .rst_n(rst_n), .scl_oe_n(scl_oe_n), .sda_oe_n(sda_oe_n), .ctl2_wr(ctl2_wr),
   .ctl2_wdata(ctl2_wdata), .ctl2(ctl2), .buf_wr(buf_wr), .buf_rd(buf_rd),
   .port_data_buffer(port_data_buffer), .port_status_reg(port_status_reg), .port_idle(port_idle)
);
`default_nettype wire

// >>> bench/tb_top.sv
// Self-checking bench for the two-wire master
`timescale 1ns/10ps
`default_nettype none
`include "i2cms_map.svh"
module tb_top;
   logic clk = 1'b0, rst_n = 1'b0, ctl2_wr = 1'b0, buf_wr = 1'b0, buf_rd = 1'b0, rx_ready = 1'b0;
   logic load = 1'b0, hold_scl = 1'b0, hold_sda = 1'b0, bf_m = 1'b0, ov_m = 1'b0;
   logic [6:0] baud = 7'h04;
   logic [4:0] ctl2_wdata = 5'h00;
   logic [7:0] buf_wdata = 8'h00, tx_byte = 8'h00, port_data_buffer, rx_data;
   logic [3:0] flag_clr = 4'h0;
   logic scl_o, scl_oe_n, sda_o, sda_oe_n, port_idle, rx_valid, slv_scl_n, slv_sda_n, scl_w, sda_w;
   i2cms_pkg::i2cms_ctl_s    ctl2;
   i2cms_pkg::i2cms_status_s status;
   logic [7:0] exp_q[$];
   int err_count = 0, check_count = 0;

   // Clock and open-drain wire resolution
   always #50 clk = ~clk;
   assign scl_w = !((!scl_oe_n && !scl_o) || !slv_scl_n);
   assign sda_w = !((!sda_oe_n && !sda_o) || !slv_sda_n);

   i2cms_top DUT (.clk(clk), .rst_n(rst_n), .scl_i(scl_w), .scl_o(scl_o), .scl_oe_n(scl_oe_n),
      .sda_i(sda_w), .sda_o(sda_o), .sda_oe_n(sda_oe_n), .baud_reload_value(baud),
      .ctl2_wr(ctl2_wr), .ctl2_wdata(ctl2_wdata), .ctl2(ctl2), .buf_wr(buf_wr),
      .buf_wdata(buf_wdata), .buf_rd(buf_rd), .port_data_buffer(port_data_buffer),
      .flag_clr(flag_clr), .port_status_reg(status), .port_idle(port_idle),
      .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready));
   i2cms_slave_model u_slave (.clk(clk), .rst_n(rst_n), .scl(scl_w), .load(load),
      .tx_byte(tx_byte), .hold_scl(hold_scl), .hold_sda(hold_sda),
      .scl_pull_n(slv_scl_n), .sda_pull_n(slv_sda_n));

   task tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick

   task chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task wr_ctl2(input logic [4:0] v);
      ctl2_wdata = v;
      ctl2_wr = 1'b1;
      tick(1);
      ctl2_wr = 1'b0;
   endtask : wr_ctl2

   task pulse(input logic [3:0] clr, input logic wr, input logic rd);
      flag_clr = clr;
      buf_wr = wr;
      buf_rd = rd;
      tick(1);
      {flag_clr, buf_wr, buf_rd} = 6'h00;
   endtask : pulse

   // Start refused on a jammed bus, then SCL pulled low during setup
   task test_collision;
      baud = 7'h14;
      for (int k = 0; k < 2; k++) begin
         {hold_scl, hold_sda} = (k == 0) ? 2'b11 : 2'b00;
         tick(6);
         wr_ctl2(5'h01);
         if (k == 1) hold_scl = 1'b1;
         for (int i = 0; i < 40 && !status.bus_collision_flag; i++) tick(1);
         chk(8'(status.bus_collision_flag), 8'h01);
         chk(8'({ctl2.start_request_bit, status.start_seen}), 8'h00);
         {hold_scl, hold_sda} = 2'b00;
         pulse(4'h1, 1'b0, 1'b0);
      end
   endtask : test_collision

   // Start timing, with a buffer write and a receive request refused meanwhile
   task test_start;
      int n;
      baud = 7'h04;
      tick(6);
      wr_ctl2(5'h01);
      buf_wdata = 8'h5A;
      pulse(4'h0, 1'b1, 1'b0);
      wr_ctl2(5'h08);
      chk(8'(status.write_collision_flag), 8'h01);
      chk(port_data_buffer, 8'h00);
      chk(8'(ctl2.receive_request_bit), 8'h00);
      for (n = 0; n < 40 && !status.start_seen; n++) tick(1);
      chk(8'({sda_w, scl_w}), 8'h01);
      for (n = 0; n < 200 && ctl2.start_request_bit; n++) tick(1);
      chk(8'(n), 8'(baud) + 8'h01);
      chk(8'(sda_oe_n), 8'h00);
      pulse(4'h2, 1'b0, 1'b0);
   endtask : test_start

   // Receive one byte; optionally try a buffer write while it shifts in
   task test_receive(input logic [7:0] b, input logic try_wr);
      tx_byte = b;
      load = 1'b1;
      tick(1);
      load = 1'b0;
      wr_ctl2(5'h08);
      exp_q.push_back(b);
      chk(8'(ctl2.receive_request_bit), 8'h01);
      if (try_wr) begin
         buf_wdata = ~b;
         pulse(4'h0, 1'b1, 1'b0);
         chk(8'(status.write_collision_flag), 8'h01);
         chk(port_data_buffer, 8'h00);
         pulse(4'h2, 1'b0, 1'b0);
      end
      for (int i = 0; i < 400 && ctl2.receive_request_bit; i++) tick(1);
      ov_m = ov_m | bf_m;
      bf_m = 1'b1;
      chk(port_data_buffer, b);
      chk(8'({status.buffer_full_flag, status.port_interrupt_flag}), 8'h03);
      chk(8'(status.receive_overflow_flag), 8'(ov_m));
      chk(8'(scl_oe_n), 8'h00);
   endtask : test_receive

   // Fill the stream FIFO until a byte stalls, then drain it in order
   task test_fifo;
      while (exp_q.size() < `I2CMS_FIFO_DEPTH) test_receive(8'h30 + 8'(exp_q.size()), 1'b0);
      tx_byte = 8'hE7;
      load = 1'b1;
      tick(1);
      load = 1'b0;
      wr_ctl2(5'h08);
      exp_q.push_back(8'hE7);
      tick(300);
      chk(8'({ctl2.receive_request_bit, scl_oe_n, rx_valid}), 8'h05);
      rx_ready = 1'b1;
      while (exp_q.size() > 0) begin
         for (int i = 0; i < 400 && !rx_valid; i++) tick(1);
         chk(rx_data, exp_q.pop_front());
         tick(1);
      end
      tick(2);
      chk(8'(rx_valid), 8'h00);
      chk(port_data_buffer, 8'hE7);
   endtask : test_fifo

   task give_verdict;
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : give_verdict

   // Main sequence
   initial begin
      repeat (12) @(posedge clk);
      #1 rst_n = 1'b1;
      tick(4);
      test_collision();
      test_start();
      test_receive(8'hC6, 1'b1);
      wr_ctl2(5'h10);
      chk(8'(ctl2.ack_sequence_request), 8'h01);
      test_receive(8'h3A, 1'b0);
      pulse(4'h0, 1'b0, 1'b1);
      bf_m = 1'b0;
      chk(8'(status.buffer_full_flag), 8'h00);
      pulse(4'hC, 1'b0, 1'b0);
      ov_m = 1'b0;
      test_fifo();
      give_verdict();
   end

   // Watchdog against a hang
   initial begin
      #1_000_000;
      err_count++;
      give_verdict();
   end
endmodule : tb_top
`default_nettype wire
